// File: verilog/iwu_regs.vh
// Constants for the interrupt and watchdog unit.
// Assumes a 100 MHz clk; included by bare name.
`ifndef IWU_REGS_VH
`define IWU_REGS_VH
// Flag and enable register bit positions
`define IWU_BIT_T0 0
`define IWU_BIT_PB 1
`define IWU_BIT_EXT 2
`define IWU_BIT_T1 3
`define IWU_BIT_WDT 6
`define IWU_FLAG_RESET 8'h00
`define IWU_ENABLE_RESET 8'h00
// Vectors
`define IWU_VEC_TRAP 11'h001
`define IWU_VEC_HW 11'h008
// Watchdog base periods, in microseconds
`define IWU_WDT_US0 3500
`define IWU_WDT_US1 15000
`define IWU_WDT_US2 60000
`define IWU_WDT_US3 250000
`define IWU_CLK_MHZ 100
// Watchdog tick: one count per microsecond of the dedicated oscillator
`define IWU_TICK_DIV 100
// Register offsets on the plain port
`define IWU_ADDR_FLAG 3'h0
`define IWU_ADDR_ENABLE 3'h1
`define IWU_ADDR_POWER 3'h2
`define IWU_ADDR_PRESCALE 3'h3
`define IWU_ADDR_PINSEL 3'h4
`define IWU_ADDR_STATUS 3'h5
`define IWU_ADDR_GLOBAL 3'h6
// Power control resets with the watchdog run bit set
`define IWU_POWER_RESET 8'h80
`endif

// File: verilog/iwu_prescaler.v
// Shared 8-bit prescaler, one pulse out per selected division.
// Assumes tick_in is a one-cycle pulse on clk.
`timescale 1ns/1ns
module iwu_prescaler (
    clk,
    reset,
    clear,
    tick_in,
    ratio_log2,
    tick_out
);
    input wire clk;
    input wire reset;
    input wire clear;
    input wire tick_in;
    input wire [3:0] ratio_log2;
    output reg tick_out;
    reg [7:0] count;
    wire [8:0] limit;
    assign limit = (9'h001 << ratio_log2) - 9'h001;
    always @(posedge clk) begin
        if (reset || clear) begin
            count <= 8'h00;
            tick_out <= 1'b0;
        end else begin
            tick_out <= 1'b0;
            if (tick_in) begin
                if ({1'b0, count} >= limit) begin
                    count <= 8'h00;
                    tick_out <= 1'b1;
                end else begin
                    count <= count + 8'h01;
                end
            end
        end
    end
endmodule // iwu_prescaler

// File: verilog/iwu_pin_watch.v
// Port-B change detection on pins 0..5 and external-edge detection on pin 0.
// Assumes pins synchronous to clk; sample strobes one instruction clock.
`timescale 1ns/1ns
module iwu_pin_watch (
    clk,
    reset,
    sample,
    pins_in,
    pins_are_input,
    pin_change_select,
    ext_irq_select,
    ext_edge_select,
    change_seen,
    edge_seen
);
    input wire clk;
    input wire reset;
    input wire sample;
    input wire [5:0] pins_in;
    input wire [5:0] pins_are_input;
    input wire [5:0] pin_change_select;
    input wire ext_irq_select;
    input wire ext_edge_select;
    output reg change_seen;
    output reg edge_seen;
    reg [5:0] last;
    reg primed;
    wire [5:0] watch;
    wire [5:0] diff;
    genvar i;
    generate
        for (i = 0; i < 6; i = i + 1) begin : g_pin
            if (i == 0) begin : g_zero
                assign watch[i] = pins_are_input[i] & pin_change_select[i] &
                    ~ext_irq_select;
            end else begin : g_other
                assign watch[i] = pins_are_input[i] & pin_change_select[i];
            end
            assign diff[i] = watch[i] & (pins_in[i] ^ last[i]);
        end
    endgenerate
    always @(posedge clk) begin
        if (reset) begin
            last <= 6'h00;
            primed <= 1'b0;
            change_seen <= 1'b0;
            edge_seen <= 1'b0;
        end else begin
            change_seen <= 1'b0;
            edge_seen <= 1'b0;
            if (sample) begin
                // First sample after reset only loads, so idle-high pins give no false event
                last <= pins_in;
                primed <= 1'b1;
                change_seen <= primed & (|diff);
                // Edge select 1 picks falling edge
                edge_seen <= primed & ext_irq_select & (ext_edge_select ?
                    (last[0] & ~pins_in[0]) : (~last[0] & pins_in[0]));
            end
        end
    end
endmodule // iwu_pin_watch

// File: verilog/iwu_irq_and_watchdog.v
// Interrupt controller with watchdog, prescaler share and vectoring.
// Assumes the core pulses instruction strobes for one cycle and clk is free running.
//
// Overview of operation
// - Watchdog counts on its own tick through standby or halt; halt entry clears its count.
// - Configured watchdog also needs runtime enable bit 7 of power control.
// - Timeout resets or interrupts per option, clearing timeout status flag.
// - Base timeout is 3.5, 15, 60 or 250 ms by two option bits.
// - Prescaler assign bit 1 gives prescaler to watchdog, 0 to timer0.
// - Watchdog ratios 1:1..1:128 in reset mode, 1:2..1:256 in interrupt mode.
// - Watchdog clear with prescaler assigned clears both, sets timeout status.
// - Interrupt-mode expiry sets flag bit 6; serviced with enables; firmware clears.
// - Trap instruction vectors to 0x001 always and clears global enable.
// - Return instruction sets global enable and resumes.
// - Global enable gates hardware interrupts; enable/disable instructions set/clear it.
// - Each event sets its sticky flag until firmware writes zero.
// - Flag reads as set only where its enable bit is 1.
// - Enabled flag with global enable vectors to 0x008, clearing global enable.
// - Timer0 wrap 0x00 to 0xFF sets timer0 flag.
// - Timer1 wrap 0xFF to 0x00 sets timer1 flag.
// - Selected input pins 0..5 changing level set port change flag.
// - External select disables change detection on pin zero.
// - Chosen edge on pin zero sets external flag when selected.
// - Halt entry clears watchdog, clears powerdown flag, sets timeout flag.
`include "iwu_regs.vh"
`timescale 1ns/1ns
module iwu_irq_and_watchdog (
    clk,
    reset,
    inst_tick,
    wdt_option_enable,
    wdt_option_irq_mode,
    wdt_option_period,
    reg_addr,
    reg_wdata,
    reg_write,
    reg_read,
    reg_rdata,
    watchdog_clear_instruction,
    enable_irq_instruction,
    disable_irq_instruction,
    return_from_irq_instruction,
    trap_instruction,
    halt_entry,
    timer0_wrap,
    timer1_wrap,
    timer0_prescaled_tick,
    timer0_source_tick,
    portb_in,
    portb_is_input,
    vector_take,
    vector_addr,
    global_irq_enable,
    watchdog_reset,
    timeout_status_flag,
    powerdown_status_flag
);
    input wire clk;
    input wire reset;
    input wire inst_tick;
    input wire wdt_option_enable;
    input wire wdt_option_irq_mode;
    input wire [1:0] wdt_option_period;
    input wire [2:0] reg_addr;
    input wire [7:0] reg_wdata;
    input wire reg_write;
    input wire reg_read;
    output reg [7:0] reg_rdata;
    input wire watchdog_clear_instruction;
    input wire enable_irq_instruction;
    input wire disable_irq_instruction;
    input wire return_from_irq_instruction;
    input wire trap_instruction;
    input wire halt_entry;
    input wire timer0_wrap;
    input wire timer1_wrap;
    output wire timer0_prescaled_tick;
    input wire timer0_source_tick;
    input wire [5:0] portb_in;
    input wire [5:0] portb_is_input;
    output reg vector_take;
    output reg [10:0] vector_addr;
    output reg global_irq_enable;
    output reg watchdog_reset;
    output reg timeout_status_flag;
    output reg powerdown_status_flag;

    // Local register indices on the plain port
    localparam [2:0] ADDR_FLAG = `IWU_ADDR_FLAG;
    localparam [2:0] ADDR_ENABLE = `IWU_ADDR_ENABLE;
    localparam [2:0] ADDR_POWER = `IWU_ADDR_POWER;
    localparam [2:0] ADDR_PRESCALE = `IWU_ADDR_PRESCALE;
    localparam [2:0] ADDR_PINSEL = `IWU_ADDR_PINSEL;
    localparam [2:0] ADDR_STATUS = `IWU_ADDR_STATUS;
    localparam [2:0] ADDR_GLOBAL = `IWU_ADDR_GLOBAL;

    localparam [2:0] ST_RUN = 3'b001;
    localparam [2:0] ST_TRAP = 3'b010;
    localparam [2:0] ST_HW = 3'b100;

    localparam [17:0] WDT_LIM0 = `IWU_WDT_US0;
    localparam [17:0] WDT_LIM1 = `IWU_WDT_US1;
    localparam [17:0] WDT_LIM2 = `IWU_WDT_US2;
    localparam [17:0] WDT_LIM3 = `IWU_WDT_US3;
    localparam [6:0] TICK_LAST = `IWU_TICK_DIV - 1;

    reg [7:0] irq_flag_reg;
    reg [7:0] irq_enable_reg;
    reg [7:0] power_control_reg;
    reg prescaler_assign_bit;
    reg [2:0] prescaler_rate_select;
    reg [5:0] pin_change_select;
    reg ext_irq_select;
    reg ext_edge_select;
    reg [6:0] osc_div;
    reg wdt_tick;
    reg [17:0] wdt_count;
    reg [17:0] wdt_limit;
    reg wdt_base_expire;
    reg [2:0] state;
    reg [2:0] next_state;
    reg [7:0] next_flag;
    reg [3:0] ratio_log2;
    reg psc_tick_in;
    reg psc_clear;
    wire psc_out;
    wire watchdog_run_enable;
    wire wdt_active;
    wire wdt_expire;
    wire port_change_evt;
    wire ext_evt;
    wire [7:0] events;
    wire pending;

    assign watchdog_run_enable = power_control_reg[7];
    assign wdt_active = wdt_option_enable & watchdog_run_enable;
    assign timer0_prescaled_tick = prescaler_assign_bit ? timer0_source_tick : psc_out;
    assign wdt_expire = prescaler_assign_bit ? psc_out : wdt_base_expire;

    // Dedicated watchdog oscillator emulated by a free-running divider
    always @(posedge clk) begin
        if (reset) begin
            osc_div <= 7'h00;
            wdt_tick <= 1'b0;
        end else begin
            wdt_tick <= (osc_div == TICK_LAST);
            osc_div <= (osc_div == TICK_LAST) ? 7'h00 : osc_div + 7'h01;
        end
    end

    always @* begin
        case (wdt_option_period)
            2'b00: wdt_limit = WDT_LIM0;
            2'b01: wdt_limit = WDT_LIM1;
            2'b10: wdt_limit = WDT_LIM2;
            default: wdt_limit = WDT_LIM3;
        endcase
    end

    always @(posedge clk) begin
        if (reset) begin
            wdt_count <= 18'h00000;
            wdt_base_expire <= 1'b0;
        end else begin
            wdt_base_expire <= 1'b0;
            if (halt_entry || (watchdog_clear_instruction && prescaler_assign_bit)) begin
                wdt_count <= 18'h00000;
            end else if (wdt_active && wdt_tick) begin
                if (wdt_count >= wdt_limit - 18'h00001) begin
                    wdt_count <= 18'h00000;
                    wdt_base_expire <= 1'b1;
                end else begin
                    wdt_count <= wdt_count + 18'h00001;
                end
            end
        end
    end

    // Prescaler source and ratio follow its assignment
    always @* begin
        if (prescaler_assign_bit) begin
            psc_tick_in = wdt_base_expire;
            ratio_log2 = {1'b0, prescaler_rate_select} +
                (wdt_option_irq_mode ? 4'h1 : 4'h0);
        end else begin
            psc_tick_in = timer0_source_tick;
            ratio_log2 = {1'b0, prescaler_rate_select} + 4'h1;
        end
        psc_clear = (reg_write && reg_addr == ADDR_PRESCALE) ||
            (watchdog_clear_instruction && prescaler_assign_bit);
    end

    iwu_prescaler u_prescaler (
        .clk(clk),
        .reset(reset),
        .clear(psc_clear),
        .tick_in(psc_tick_in),
        .ratio_log2(ratio_log2),
        .tick_out(psc_out)
    );

    iwu_pin_watch u_pins (
        .clk(clk),
        .reset(reset),
        .sample(inst_tick),
        .pins_in(portb_in),
        .pins_are_input(portb_is_input),
        .pin_change_select(pin_change_select),
        .ext_irq_select(ext_irq_select),
        .ext_edge_select(ext_edge_select),
        .change_seen(port_change_evt),
        .edge_seen(ext_evt)
    );

    // Watchdog flag only in interrupt mode; reset mode pulses watchdog_reset instead
    assign events = {1'b0, wdt_expire & wdt_active & wdt_option_irq_mode, 2'b00,
        timer1_wrap, ext_evt, port_change_evt, timer0_wrap};

    // A hardware set beats a firmware clear in the same cycle
    always @* begin
        next_flag = irq_flag_reg;
        if (reg_write && reg_addr == ADDR_FLAG) begin
            next_flag = reg_wdata & 8'h4f;
        end
        next_flag = next_flag | events;
    end

    assign pending = |(irq_flag_reg & irq_enable_reg) & global_irq_enable;

    always @* begin
        // Trap wins over a hardware vector; a return cycle holds the hardware vector off
        case (state)
            ST_RUN: begin
                if (trap_instruction) begin
                    next_state = ST_TRAP;
                end else if (pending && !return_from_irq_instruction) begin
                    next_state = ST_HW;
                end else begin
                    next_state = ST_RUN;
                end
            end
            ST_TRAP, ST_HW: begin
                // A trap right after a vector is still taken
                if (trap_instruction) begin
                    next_state = ST_TRAP;
                end else begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_RUN;
        endcase
    end

    always @(posedge clk) begin
        if (reset) begin
            state <= ST_RUN;
            irq_flag_reg <= `IWU_FLAG_RESET;
            irq_enable_reg <= `IWU_ENABLE_RESET;
            power_control_reg <= `IWU_POWER_RESET;
            prescaler_assign_bit <= 1'b0;
            prescaler_rate_select <= 3'h0;
            pin_change_select <= 6'h00;
            ext_irq_select <= 1'b0;
            ext_edge_select <= 1'b0;
            global_irq_enable <= 1'b0;
            vector_take <= 1'b0;
            vector_addr <= 11'h000;
            watchdog_reset <= 1'b0;
            timeout_status_flag <= 1'b1;
            powerdown_status_flag <= 1'b1;
        end else begin
            state <= next_state;
            irq_flag_reg <= next_flag;
            vector_take <= 1'b0;
            watchdog_reset <= 1'b0;
            // Instruction effects below override a register write in the same cycle
            if (reg_write) begin
                case (reg_addr)
                    ADDR_ENABLE: irq_enable_reg <= reg_wdata & 8'h4f;
                    ADDR_POWER: power_control_reg <= reg_wdata & 8'h80;
                    ADDR_PRESCALE: begin
                        prescaler_assign_bit <= reg_wdata[3];
                        prescaler_rate_select <= reg_wdata[2:0];
                    end
                    ADDR_PINSEL: begin
                        pin_change_select <= reg_wdata[5:0];
                        ext_irq_select <= reg_wdata[6];
                        ext_edge_select <= reg_wdata[7];
                    end
                    ADDR_GLOBAL: global_irq_enable <= reg_wdata[0];
                    default: ;
                endcase
            end
            if (enable_irq_instruction || return_from_irq_instruction) begin
                global_irq_enable <= 1'b1;
            end else if (disable_irq_instruction) begin
                global_irq_enable <= 1'b0;
            end
            if (next_state == ST_TRAP) begin
                global_irq_enable <= 1'b0;
                vector_take <= 1'b1;
                vector_addr <= `IWU_VEC_TRAP;
            end else if (next_state == ST_HW) begin
                global_irq_enable <= 1'b0;
                vector_take <= 1'b1;
                vector_addr <= `IWU_VEC_HW;
            end
            if (halt_entry) begin
                powerdown_status_flag <= 1'b0;
                timeout_status_flag <= 1'b1;
            end
            if (watchdog_clear_instruction && prescaler_assign_bit) begin
                timeout_status_flag <= 1'b1;
            end
            // Expiry comes last so a timeout beats a halt or clear in the same cycle
            if (wdt_expire && wdt_active) begin
                timeout_status_flag <= 1'b0;
                watchdog_reset <= ~wdt_option_irq_mode;
            end
        end
    end

    // Read data stands for the one cycle after the strobe, zero otherwise
    always @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                ADDR_FLAG: reg_rdata <= irq_flag_reg & irq_enable_reg;
                ADDR_ENABLE: reg_rdata <= irq_enable_reg;
                ADDR_POWER: reg_rdata <= power_control_reg;
                ADDR_PRESCALE: reg_rdata <= {4'h0, prescaler_assign_bit, prescaler_rate_select};
                ADDR_PINSEL: reg_rdata <= {ext_edge_select, ext_irq_select, pin_change_select};
                ADDR_STATUS: reg_rdata <= {3'h0, timeout_status_flag, powerdown_status_flag, 3'h0};
                ADDR_GLOBAL: reg_rdata <= {7'h00, global_irq_enable};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule // iwu_irq_and_watchdog

// File: test/iwu_core_model.sv
// Core and event source model: instruction strobes, timer wraps, instruction clock.
// Assumes op_go is a one-cycle request from the bench.
`timescale 1ns/1ns
module iwu_core_model (
    input wire clk,
    input wire reset,
    input wire op_go,
    input wire [2:0] op_code,
    output wire inst_tick,
    output wire enable_irq_instruction,
    output wire disable_irq_instruction,
    output wire return_from_irq_instruction,
    output wire trap_instruction,
    output wire watchdog_clear_instruction,
    output wire halt_entry,
    output wire timer0_wrap,
    output wire timer1_wrap
);
    reg [7:0] pulse;
    reg [1:0] div;
    assign {timer1_wrap, timer0_wrap, halt_entry, watchdog_clear_instruction, trap_instruction,
        return_from_irq_instruction, disable_irq_instruction, enable_irq_instruction} = pulse;
    assign inst_tick = (div == 2'h3);
    always @(posedge clk) begin
        if (reset) begin
            pulse <= 8'h00;
            div <= 2'h0;
        end else begin
            // One strobe per request, so never enable and return in the same cycle
            pulse <= op_go ? (8'h01 << op_code) : 8'h00;
            div <= div + 2'h1;
        end
    end
endmodule // iwu_core_model

// File: test/iwu_irq_and_watchdog_monitor.sv
// Concurrent checks on the interrupt and watchdog unit ports.
// Assumes one clock domain and synchronous active-high reset.
`include "iwu_regs.vh"
`timescale 1ns/1ns
module iwu_irq_monitor (
    input wire clk,
    input wire reset,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire watchdog_clear_instruction,
    input wire enable_irq_instruction,
    input wire disable_irq_instruction,
    input wire return_from_irq_instruction,
    input wire trap_instruction,
    input wire halt_entry,
    input wire vector_take,
    input wire [10:0] vector_addr,
    input wire global_irq_enable,
    input wire watchdog_reset,
    input wire timeout_status_flag,
    input wire powerdown_status_flag
);
    reg presc_on;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    always @(posedge clk) begin
        if (reset) begin
            presc_on <= 1'b0;
        end else if (reg_write && reg_addr == 3'h3) begin
            presc_on <= reg_wdata[3];
        end
    end
    trap_vector_a: assert property (trap_instruction |=>
        vector_take && vector_addr == `IWU_VEC_TRAP && !global_irq_enable) else $error("trap vector");
    return_gie_a: assert property (return_from_irq_instruction && !trap_instruction &&
        !disable_irq_instruction |=> global_irq_enable) else $error("return gie");
    enable_gie_a: assert property (enable_irq_instruction && !global_irq_enable &&
        !trap_instruction && !disable_irq_instruction |=> global_irq_enable) else $error("enable");
    disable_gie_a: assert property (disable_irq_instruction && !enable_irq_instruction &&
        !return_from_irq_instruction |=> !global_irq_enable) else $error("disable");
    vector_gie_a: assert property (vector_take |-> !global_irq_enable) else $error("vec gie");
    vector_addr_a: assert property (vector_take && !$past(trap_instruction) |->
        vector_addr == `IWU_VEC_HW) else $error("hw vector addr");
    single_vector_a: assert property (vector_take && !trap_instruction |=>
        !vector_take) else $error("double vector");
    halt_status_a: assert property (halt_entry |=>
        !powerdown_status_flag && timeout_status_flag) else $error("halt status");
    clear_status_a: assert property (watchdog_clear_instruction && presc_on |=>
        timeout_status_flag) else $error("clear status");
    reset_status_a: assert property (watchdog_reset |-> !timeout_status_flag)
        else $error("timeout flag");
endmodule // iwu_irq_monitor
bind iwu_irq_and_watchdog iwu_irq_monitor iwu_irq_monitor_i (.clk(clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .watchdog_clear_instruction(watchdog_clear_instruction),
    .enable_irq_instruction(enable_irq_instruction),
    .disable_irq_instruction(disable_irq_instruction),
    .return_from_irq_instruction(return_from_irq_instruction),
    .trap_instruction(trap_instruction), .halt_entry(halt_entry), .vector_take(vector_take),
    .vector_addr(vector_addr), .global_irq_enable(global_irq_enable),
    .watchdog_reset(watchdog_reset), .timeout_status_flag(timeout_status_flag),
    .powerdown_status_flag(powerdown_status_flag));

// File: test/iwu_irq_and_watchdog_tb_top.sv
// Self-checking bench for the interrupt and watchdog unit.
// Assumes the core model makes strobes and the bench drives the register port and pins.
`include "iwu_regs.vh"
`timescale 1ns/1ns
module iwu_irq_and_watchdog_tb_top;
    reg clk = 1'b0;
    reg reset = 1'b1;
    reg [2:0] reg_addr = 3'h0;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_write = 1'b0;
    reg reg_read = 1'b0;
    reg op_go = 1'b0;
    reg [2:0] op_code = 3'h0;
    reg [5:0] portb_in = 6'h00;
    reg [5:0] portb_is_input = 6'h3f;
    reg [7:0] m_flag;
    reg [7:0] m_en;
    reg t0_src = 1'b0;
    wire t0_tick_out;
    integer t0_ticks = 0, k;
    wire [7:0] reg_rdata;
    wire [10:0] vector_addr;
    wire inst_tick, en_i, dis_i, ret_i, trap_i, clr_i, halt_i, t0w, t1w;
    wire vector_take, global_irq_enable, watchdog_reset, to_flag, pd_flag;
    integer mismatches = 0, comparisons = 0, cycles = 0, seed = 32'h2419, i, j;
    iwu_core_model iwu_core_model_i (.clk(clk), .reset(reset), .op_go(op_go),
        .op_code(op_code), .inst_tick(inst_tick), .enable_irq_instruction(en_i),
        .disable_irq_instruction(dis_i), .return_from_irq_instruction(ret_i),
        .trap_instruction(trap_i), .watchdog_clear_instruction(clr_i), .halt_entry(halt_i),
        .timer0_wrap(t0w), .timer1_wrap(t1w));
    iwu_irq_and_watchdog iwu_irq_and_watchdog_i (.clk(clk), .reset(reset),
        .inst_tick(inst_tick), .wdt_option_enable(1'b1), .wdt_option_irq_mode(1'b1),
        .wdt_option_period(2'h0), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .watchdog_clear_instruction(clr_i), .enable_irq_instruction(en_i),
        .disable_irq_instruction(dis_i), .return_from_irq_instruction(ret_i),
        .trap_instruction(trap_i), .halt_entry(halt_i), .timer0_wrap(t0w), .timer1_wrap(t1w),
        .timer0_prescaled_tick(t0_tick_out), .timer0_source_tick(t0_src), .portb_in(portb_in),
        .portb_is_input(portb_is_input), .vector_take(vector_take), .vector_addr(vector_addr),
        .global_irq_enable(global_irq_enable), .watchdog_reset(watchdog_reset),
        .timeout_status_flag(to_flag), .powerdown_status_flag(pd_flag));
    initial begin
        forever #5 clk = ~clk;
    end
    task report_and_stop;
        begin
            if (mismatches == 0 && comparisons > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask
    task chk(input string what, input [10:0] exp, input [10:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("BAD %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task wr(input [2:0] a, input [7:0] d);
        begin
            @(posedge clk);
            reg_write <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge clk);
            reg_write <= 1'b0;
        end
    endtask
    task rd(input [2:0] a, input [7:0] e);
        begin
            @(posedge clk);
            reg_read <= 1'b1;
            reg_addr <= a;
            @(posedge clk);
            reg_read <= 1'b0;
            #1 chk("rdata", {3'h0, e}, {3'h0, reg_rdata});
        end
    endtask
    task op(input [2:0] c);
        begin
            @(posedge clk);
            op_go <= 1'b1;
            op_code <= c;
            @(posedge clk);
            op_go <= 1'b0;
            @(posedge clk);
            #1;
        end
    endtask
    task wait_vec(input [10:0] a);
        begin
            j = 0;
            while (vector_take !== 1'b1 && j < 8) begin
                @(posedge clk);
                #1 j = j + 1;
            end
            chk("vector_take", 11'h001, {10'h000, vector_take});
            chk("vector_addr", a, vector_addr);
            chk("gie", 11'h000, {10'h000, global_irq_enable});
        end
    endtask
    task pins(input [5:0] p);
        begin
            @(posedge clk);
            portb_in <= p;
            repeat (12) @(posedge clk);
        end
    endtask
    task src_run(input integer n);
        begin
            @(posedge clk);
            t0_src <= 1'b1;
            repeat (n) @(posedge clk);
            t0_src <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (t0_tick_out === 1'b1) begin
            t0_ticks = t0_ticks + 1;
        end
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            report_and_stop;
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        #1 chk("gie", 11'h000, {10'h000, global_irq_enable});
        rd(3'h5, 8'h18);
        rd(3'h2, 8'h80);
        wr(3'h7, 8'hff);
        rd(3'h7, 8'h00);
        for (i = 0; i < 8; i = i + 1) begin
            m_en = $random(seed) & 8'h4f;
            m_flag = $random(seed) & 8'h4f;
            wr(3'h1, m_en);
            wr(3'h0, m_flag);
            rd(3'h0, m_flag & m_en);
            rd(3'h1, m_en);
        end
        m_en = 8'h4f;
        wr(3'h1, m_en);
        wr(3'h0, 8'h00);
        op(3'h6);
        op(3'h7);
        m_flag = 8'h09;
        rd(3'h0, m_flag);
        wr(3'h4, 8'h3f);
        pins(6'h08);
        m_flag = m_flag | 8'h02;
        rd(3'h0, m_flag);
        wr(3'h0, 8'h09);
        wr(3'h4, 8'h41);
        pins(6'h09);
        m_flag = 8'h0d;
        rd(3'h0, m_flag);
        op(3'h0);
        wait_vec(`IWU_VEC_HW);
        rd(3'h0, m_flag);
        op(3'h3);
        wait_vec(`IWU_VEC_TRAP);
        wr(3'h0, 8'h00);
        rd(3'h0, 8'h00);
        op(3'h2);
        chk("gie", 11'h001, {10'h000, global_irq_enable});
        op(3'h1);
        chk("gie", 11'h000, {10'h000, global_irq_enable});
        wr(3'h3, 8'h01);
        k = t0_ticks;
        src_run(16);
        chk("t0_ticks", 11'h004, t0_ticks - k);
        wr(3'h3, 8'h08);
        k = t0_ticks;
        src_run(5);
        chk("t0_ticks", 11'h005, t0_ticks - k);
        op(3'h5);
        rd(3'h5, 8'h10);
        op(3'h4);
        rd(3'h5, 8'h10);
        chk("watchdog_reset", 11'h000, {10'h000, watchdog_reset});
        report_and_stop;
    end
endmodule // iwu_irq_and_watchdog_tb_top
